// ==== rtl/indirect_address_generator.sv ====
`timescale 1ns/1ps
// Overview of operation
// - unmodified mode uses pointer register value as address, no update
// - pre-increment adds 1 or 2 then uses updated pointer
// - pre-decrement subtracts 1 or 2 then uses reduced pointer
// - post-increment uses original pointer then adds 1 or 2
// - post-decrement uses original pointer then subtracts 1 or 2
// - register offset address is base plus offset, neither modified
// - register offset sum is never scaled for word operations
// - pointer write-back happens in the operation cycle, no extra cycles
// - literal offset move adds sign-extended ten-bit literal to pointer
// - five basic modes everywhere; register offset only for moves and accumulator ops
// - multiply-accumulate does two prefetches, X and Y, own addresses
// - prefetch modes none, post-increment or post-decrement by 2, 4, 6
// - prefetches are word-only, no odd-sized updates
// - prefetch register offset: X is reg9+reg12, Y is reg11+reg12
// - X prefetch pointers are regs 8 or 9, Y are regs 10 or 11
// - immediates of 1,4,5,6,8,10,14,16 bits extracted per instruction type
// - signed 4, 6, 10-bit immediates sign-extend, others zero-extend
// - modulo and bit-reversed sequencing available to indirect users, outside block
// - effective addresses reach the whole 64K byte data space
// - words little-endian, low byte at even address
module indirect_address_generator
	import indirect_address_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_op_valid,
	input wire ind_mode_t i_mode,
	input wire logic i_byte_op,
	input wire logic i_offset_mode_allowed,
	input wire logic [3:0] i_pointer_sel,
	input wire logic [3:0] i_offset_sel,
	input wire logic [9:0] i_signed_ten_bit_literal,
	input wire logic i_mac_valid,
	input wire mac_mode_t i_mac_x_mode,
	input wire mac_mode_t i_mac_y_mode,
	input wire logic i_mac_x_sel,
	input wire logic i_mac_y_sel,
	input wire imm_kind_t i_imm_kind,
	input wire logic [15:0] i_instr_word,
	input wire logic i_imm_wide_sel,
	input wire logic [15:0] i_sixteen_bit_literal,
	input wire logic [13:0] i_fourteen_bit_literal,
	input wire logic [255:0] i_reg_array,
	output logic [15:0] o_effective_address,
	output logic o_addr_valid,
	output logic o_mode_error,
	output logic o_ptr_we,
	output logic [3:0] o_ptr_sel,
	output logic [15:0] o_ptr_wdata,
	output logic [15:0] o_x_effective_address,
	output logic [15:0] o_y_effective_address,
	output logic o_mac_valid,
	output logic o_x_ptr_we,
	output logic [3:0] o_x_ptr_sel,
	output logic [15:0] o_x_ptr_wdata,
	output logic o_y_ptr_we,
	output logic [3:0] o_y_ptr_sel,
	output logic [15:0] o_y_ptr_wdata,
	output logic [15:0] o_immediate
);
	// ==========================================
	// register array view
	logic [15:0] regs [NUM_REGS];
	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : g_regs
			assign regs[g] = i_reg_array[g*ADDR_W +: ADDR_W];
		end
	endgenerate

	// ==========================================
	// basic indirect modes
	wire logic [15:0] pointer_reg;
	wire logic [15:0] offset_reg;
	wire logic [15:0] step;
	wire logic [15:0] ptr_inc;
	wire logic [15:0] ptr_dec;
	wire logic [15:0] lit_ext;
	wire logic offset_illegal;
	logic [15:0] next_ea;
	logic [15:0] next_ptr;
	logic next_we;

	assign pointer_reg = regs[i_pointer_sel];
	assign offset_reg = regs[i_offset_sel];
	assign step = i_byte_op ? STEP_BYTE : STEP_WORD;
	assign ptr_inc = pointer_reg + step;
	assign ptr_dec = pointer_reg - step;
	assign lit_ext = {{(ADDR_W-LIT10_W){i_signed_ten_bit_literal[LIT10_W-1]}},
		i_signed_ten_bit_literal};
	assign offset_illegal = i_mode == MODE_REG_OFFSET && !i_offset_mode_allowed;

	always_comb begin
		next_ea = pointer_reg;
		next_ptr = pointer_reg;
		next_we = 1'b0;
		case (i_mode)
			MODE_NONE: begin
				next_ea = pointer_reg;
			end
			MODE_PRE_INC: begin
				next_ea = ptr_inc;
				next_ptr = ptr_inc;
				next_we = 1'b1;
			end
			MODE_PRE_DEC: begin
				next_ea = ptr_dec;
				next_ptr = ptr_dec;
				next_we = 1'b1;
			end
			MODE_POST_INC: begin
				next_ea = pointer_reg;
				next_ptr = ptr_inc;
				next_we = 1'b1;
			end
			MODE_POST_DEC: begin
				next_ea = pointer_reg;
				next_ptr = ptr_dec;
				next_we = 1'b1;
			end
			MODE_REG_OFFSET: begin
				next_ea = pointer_reg + offset_reg;
			end
			MODE_LIT_OFFSET: begin
				next_ea = pointer_reg + lit_ext;
			end
			default: begin
				next_ea = pointer_reg;
			end
		endcase
	end

	// ==========================================
	// mac prefetch units
	mac_prefetch_if x_if ();
	mac_prefetch_if y_if ();
	wire logic [3:0] x_sel;
	wire logic [3:0] y_sel;

	// x pointer limited to regs 8/9, y to 10/11; offset mode fixed regs
	assign x_sel = (i_mac_x_mode == MAC_REG_OFFSET) ? REG_X_HI
		: (i_mac_x_sel ? REG_X_HI : REG_X_LO);
	assign y_sel = (i_mac_y_mode == MAC_REG_OFFSET) ? REG_Y_HI
		: (i_mac_y_sel ? REG_Y_HI : REG_Y_LO);
	assign x_if.pointer_value = regs[x_sel];
	assign x_if.offset_value = regs[REG_MAC_OFFSET];
	assign x_if.mode = i_mac_x_mode;
	assign y_if.pointer_value = regs[y_sel];
	assign y_if.offset_value = regs[REG_MAC_OFFSET];
	assign y_if.mode = i_mac_y_mode;

	mac_prefetch_calc u_x_calc (
		.port(x_if.calc)
	);
	mac_prefetch_calc u_y_calc (
		.port(y_if.calc)
	);

	// ==========================================
	// immediate extraction
	logic [15:0] next_imm;
	always_comb begin
		next_imm = 16'h0000;
		case (i_imm_kind)
			IMM_LIT1: next_imm = {15'h0000, i_instr_word[0]};
			IMM_LIT4: next_imm = {12'h000, i_instr_word[3:0]};
			IMM_SIGNED_FOUR_BIT_LITERAL: next_imm = {{12{i_instr_word[3]}}, i_instr_word[3:0]};
			IMM_LIT5: next_imm = {11'h000, i_instr_word[4:0]};
			IMM_SIGNED_SIX_BIT_LITERAL: next_imm = {{10{i_instr_word[5]}}, i_instr_word[5:0]};
			IMM_LIT8: next_imm = {8'h00, i_instr_word[7:0]};
			IMM_LIT10: next_imm = i_imm_wide_sel ? {2'h0, i_fourteen_bit_literal}
				: {6'h00, i_instr_word[9:0]};
			IMM_SIGNED_TEN_BIT_LITERAL: next_imm = i_imm_wide_sel ? i_sixteen_bit_literal
				: {{6{i_instr_word[9]}}, i_instr_word[9:0]};
			default: next_imm = 16'h0000;
		endcase
	end

	// ==========================================
	// registered outputs, one cycle per operation
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_effective_address <= 16'h0000;
			o_addr_valid <= 1'b0;
			o_mode_error <= 1'b0;
			o_ptr_we <= 1'b0;
			o_ptr_sel <= 4'h0;
			o_ptr_wdata <= 16'h0000;
			o_immediate <= 16'h0000;
		end else begin
			o_effective_address <= next_ea;
			o_addr_valid <= i_op_valid && !offset_illegal;
			o_mode_error <= i_op_valid && offset_illegal;
			o_ptr_we <= i_op_valid && !offset_illegal && next_we;
			o_ptr_sel <= i_pointer_sel;
			o_ptr_wdata <= next_ptr;
			o_immediate <= next_imm;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_x_effective_address <= 16'h0000;
			o_y_effective_address <= 16'h0000;
			o_mac_valid <= 1'b0;
			o_x_ptr_we <= 1'b0;
			o_y_ptr_we <= 1'b0;
			o_x_ptr_sel <= 4'h0;
			o_y_ptr_sel <= 4'h0;
			o_x_ptr_wdata <= 16'h0000;
			o_y_ptr_wdata <= 16'h0000;
		end else begin
			o_x_effective_address <= x_if.effective_address;
			o_y_effective_address <= y_if.effective_address;
			o_mac_valid <= i_mac_valid;
			o_x_ptr_we <= i_mac_valid && x_if.writes_pointer;
			o_y_ptr_we <= i_mac_valid && y_if.writes_pointer;
			o_x_ptr_sel <= x_sel;
			o_y_ptr_sel <= y_sel;
			o_x_ptr_wdata <= x_if.next_pointer;
			o_y_ptr_wdata <= y_if.next_pointer;
		end
	end

	// ==========================================
	// checks, basic modes
	AST_NO_MOD: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_NONE |=> !o_ptr_we
		&& o_effective_address == $past(pointer_reg))
		else $error("unmodified mode wrong");
	AST_PRE_INC: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_PRE_INC |=> o_ptr_we
		&& o_effective_address == o_ptr_wdata
		&& o_ptr_wdata == $past(pointer_reg) + ($past(i_byte_op) ? STEP_BYTE : STEP_WORD))
		else $error("pre-increment update wrong");
	AST_PRE_DEC: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_PRE_DEC |=> o_ptr_we && o_effective_address == o_ptr_wdata)
		else $error("pre-decrement address not updated pointer");
	AST_PRE_DEC_VAL: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_PRE_DEC
		|=> o_ptr_wdata == $past(pointer_reg) - ($past(i_byte_op) ? STEP_BYTE : STEP_WORD))
		else $error("pre-decrement step wrong");
	AST_POST_INC: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_POST_INC |=> o_ptr_we
		&& o_ptr_wdata == o_effective_address + ($past(i_byte_op) ? STEP_BYTE : STEP_WORD))
		else $error("post-increment update wrong");
	AST_POST_DEC: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_POST_DEC |=> o_ptr_we
		&& o_ptr_wdata == o_effective_address - ($past(i_byte_op) ? STEP_BYTE : STEP_WORD))
		else $error("post-decrement update wrong");
	AST_POST_ADDR: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && (i_mode == MODE_POST_INC || i_mode == MODE_POST_DEC)
		|=> o_effective_address == $past(pointer_reg))
		else $error("post mode address not original pointer");
	AST_REG_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_REG_OFFSET && i_offset_mode_allowed |=> !o_ptr_we
		&& o_effective_address == $past(pointer_reg) + $past(offset_reg))
		else $error("register offset wrong");
	AST_OFF_UNSCALED: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_REG_OFFSET && !i_byte_op
		|=> o_effective_address == $past(pointer_reg) + $past(offset_reg))
		else $error("register offset scaled for word operation");
	AST_WB_CYCLE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && (i_mode == MODE_PRE_INC || i_mode == MODE_PRE_DEC
		|| i_mode == MODE_POST_INC || i_mode == MODE_POST_DEC)
		|=> o_ptr_we && o_addr_valid && o_ptr_sel == $past(i_pointer_sel))
		else $error("pointer write-back not in operation cycle");
	AST_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!i_op_valid |=> !o_ptr_we && !o_addr_valid && !o_mode_error)
		else $error("write-back without operation");
	AST_LIT_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mode == MODE_LIT_OFFSET |=> o_effective_address
		== $past(pointer_reg) + $past(lit_ext))
		else $error("literal offset wrong");
	AST_LIT_NO_WR: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode == MODE_LIT_OFFSET |=> !o_ptr_we)
		else $error("literal offset modified pointer");
	AST_OFF_REFUSED: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && offset_illegal |=> o_mode_error && !o_addr_valid && !o_ptr_we)
		else $error("illegal offset mode accepted");
	AST_BASIC_OK: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && i_mode != MODE_REG_OFFSET |=> o_addr_valid && !o_mode_error)
		else $error("basic mode refused");
	AST_WORD_LANE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_op_valid && !i_byte_op && i_mode != MODE_REG_OFFSET && i_mode != MODE_LIT_OFFSET
		|=> o_ptr_wdata[0] == o_effective_address[0])
		else $error("word update left word alignment");

	// ==========================================
	// checks, prefetch
	AST_MAC_VALID: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mac_valid |=> o_mac_valid)
		else $error("prefetch not flagged");
	AST_MAC_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!i_mac_valid |=> !o_mac_valid && !o_x_ptr_we && !o_y_ptr_we)
		else $error("prefetch write without operation");
	AST_MAC_X_POST: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mac_valid && i_mac_x_mode != MAC_REG_OFFSET
		|=> o_x_effective_address == $past(x_if.pointer_value))
		else $error("prefetch address not original pointer");
	AST_MAC_X_INC4: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mac_valid && i_mac_x_mode == MAC_INC_4
		|=> o_x_ptr_we && o_x_ptr_wdata == o_x_effective_address + STEP_MAC_4)
		else $error("prefetch increment by four wrong");
	AST_MAC_Y_DEC6: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mac_valid && i_mac_y_mode == MAC_DEC_6
		|=> o_y_ptr_we && o_y_ptr_wdata == o_y_effective_address - STEP_MAC_6)
		else $error("prefetch decrement by six wrong");
	AST_MAC_EVEN: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		o_x_ptr_we |-> o_x_ptr_wdata[0] == o_x_effective_address[0])
		else $error("odd prefetch update");
	AST_MAC_EVEN_Y: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		o_y_ptr_we |-> o_y_ptr_wdata[0] == o_y_effective_address[0])
		else $error("odd y prefetch update");
	AST_MAC_X_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mac_valid && i_mac_x_mode == MAC_REG_OFFSET |=> !o_x_ptr_we
		&& o_x_effective_address == $past(regs[REG_X_HI]) + $past(regs[REG_MAC_OFFSET]))
		else $error("x prefetch offset wrong");
	AST_MAC_Y_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mac_valid && i_mac_y_mode == MAC_REG_OFFSET |=> !o_y_ptr_we
		&& o_y_effective_address == $past(regs[REG_Y_HI]) + $past(regs[REG_MAC_OFFSET]))
		else $error("y prefetch offset wrong");
	AST_MAC_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		o_mac_valid |-> (o_x_ptr_sel == REG_X_LO || o_x_ptr_sel == REG_X_HI)
		&& (o_y_ptr_sel == REG_Y_LO || o_y_ptr_sel == REG_Y_HI))
		else $error("prefetch pointer outside allowed set");
	AST_MAC_X_PICK: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_mac_valid && i_mac_x_mode != MAC_REG_OFFSET
		|=> o_x_ptr_sel == ($past(i_mac_x_sel) ? REG_X_HI : REG_X_LO))
		else $error("x prefetch pointer not the selected one");

	// ==========================================
	// checks, immediates
	AST_SIGN: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_imm_kind == IMM_SIGNED_SIX_BIT_LITERAL |=> o_immediate[15:6] == {10{$past(i_instr_word[5])}})
		else $error("six-bit literal not sign-extended");
	AST_SIGN4: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_imm_kind == IMM_SIGNED_FOUR_BIT_LITERAL |=> o_immediate[15:4] == {12{$past(i_instr_word[3])}})
		else $error("four-bit literal not sign-extended");
	AST_SIGN10: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_imm_kind == IMM_SIGNED_TEN_BIT_LITERAL && !i_imm_wide_sel
		|=> o_immediate[15:10] == {6{$past(i_instr_word[9])}})
		else $error("ten-bit literal not sign-extended");
	AST_UNSIGNED: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_imm_kind == IMM_LIT8 |=> o_immediate[15:8] == 8'h00)
		else $error("eight-bit literal not zero-extended");
	AST_SIXTEEN_BIT_LITERAL: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_imm_kind == IMM_SIGNED_TEN_BIT_LITERAL && i_imm_wide_sel
		|=> o_immediate == $past(i_sixteen_bit_literal))
		else $error("sixteen-bit literal wrong");
	AST_FOURTEEN_BIT_LITERAL: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		i_imm_kind == IMM_LIT10 && i_imm_wide_sel
		|=> o_immediate == {2'h0, $past(i_fourteen_bit_literal)})
		else $error("fourteen-bit literal wrong");
endmodule : indirect_address_generator

// ==== rtl/indirect_address_pkg.sv ====
package indirect_address_pkg;
	localparam int ADDR_W = 16;
	localparam int REG_SEL_W = 4;
	localparam int NUM_REGS = 16;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] STEP_MAC_2 = 16'h0002;
	localparam logic [15:0] STEP_MAC_4 = 16'h0004;
	localparam logic [15:0] STEP_MAC_6 = 16'h0006;
	localparam logic [3:0] REG_X_LO = 4'h8;
	localparam logic [3:0] REG_X_HI = 4'h9;
	localparam logic [3:0] REG_Y_LO = 4'ha;
	localparam logic [3:0] REG_Y_HI = 4'hb;
	localparam logic [3:0] REG_MAC_OFFSET = 4'hc;
	localparam int LIT10_W = 10;

	typedef enum logic [2:0] {
		MODE_NONE,
		MODE_PRE_INC,
		MODE_PRE_DEC,
		MODE_POST_INC,
		MODE_POST_DEC,
		MODE_REG_OFFSET,
		MODE_LIT_OFFSET
	} ind_mode_t;

	typedef enum logic [2:0] {
		MAC_NONE,
		MAC_INC_2,
		MAC_INC_4,
		MAC_INC_6,
		MAC_DEC_2,
		MAC_DEC_4,
		MAC_DEC_6,
		MAC_REG_OFFSET
	} mac_mode_t;

	typedef enum logic [2:0] {
		IMM_LIT1,
		IMM_LIT4,
		IMM_SIGNED_FOUR_BIT_LITERAL,
		IMM_LIT5,
		IMM_SIGNED_SIX_BIT_LITERAL,
		IMM_LIT8,
		IMM_LIT10,
		IMM_SIGNED_TEN_BIT_LITERAL
	} imm_kind_t;
endpackage : indirect_address_pkg

// ==== rtl/mac_prefetch_calc.sv ====
`timescale 1ns/1ps
module mac_prefetch_calc
	import indirect_address_pkg::*;
(
	mac_prefetch_if.calc port
);
	wire logic is_dec;
	wire logic [15:0] step;
	wire logic [15:0] offset_sum;

	// only even steps, word mode
	assign step = (port.mode == MAC_INC_4 || port.mode == MAC_DEC_4) ? STEP_MAC_4 :
		(port.mode == MAC_INC_6 || port.mode == MAC_DEC_6) ? STEP_MAC_6 : STEP_MAC_2;
	assign is_dec = port.mode == MAC_DEC_2 || port.mode == MAC_DEC_4 || port.mode == MAC_DEC_6;
	assign offset_sum = port.pointer_value + port.offset_value;
	// post modify: address is the original pointer
	assign port.effective_address = (port.mode == MAC_REG_OFFSET) ? offset_sum
		: port.pointer_value;
	assign port.next_pointer = is_dec ? port.pointer_value - step
		: port.pointer_value + step;
	assign port.writes_pointer = port.mode != MAC_NONE && port.mode != MAC_REG_OFFSET;
endmodule : mac_prefetch_calc

// ==== rtl/mac_prefetch_if.sv ====
`timescale 1ns/1ps
interface mac_prefetch_if;
	import indirect_address_pkg::*;
	logic [15:0] pointer_value;
	logic [15:0] offset_value;
	mac_mode_t mode;
	logic [15:0] effective_address;
	logic [15:0] next_pointer;
	logic writes_pointer;
	modport calc (
		input pointer_value,
		input offset_value,
		input mode,
		output effective_address,
		output next_pointer,
		output writes_pointer
	);
	modport user (
		output pointer_value,
		output offset_value,
		output mode,
		input effective_address,
		input next_pointer,
		input writes_pointer
	);
endinterface : mac_prefetch_if

// ==== tb/indirect_address_generator_tb.sv ====
`timescale 1ns/1ps
module indirect_address_generator_tb;
	import indirect_address_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	logic op_v = 1'b0, byte_op = 1'b0, allow = 1'b0, mac_v = 1'b0, wide = 1'b0, ld = 1'b0;
	logic xs = 1'b0, ys = 1'b0;
	ind_mode_t mode = MODE_NONE;
	mac_mode_t xm = MAC_NONE, ym = MAC_NONE;
	imm_kind_t ik = IMM_LIT1;
	logic [3:0] psel = 4'h3, osel = 4'h4, ld_sel = 4'h0;
	logic [9:0] lit = 10'h000;
	logic [15:0] iw = 16'h02aa, l16 = 16'hbeef, ld_val = 16'h0000;
	logic [13:0] l14 = 14'h2abc;
	logic [255:0] regs;
	logic [15:0] ea, pwd, xea, yea, xwd, ywd, imm;
	logic av, merr, pwe, mv, xwe, ywe;
	logic [3:0] psl, xsl, ysl;
	int error_cnt = 0, checks = 0;
	always #12.5 i_clk_sys = ~i_clk_sys;
	indirect_address_generator uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_op_valid(op_v), .i_mode(mode), .i_byte_op(byte_op), .i_offset_mode_allowed(allow),
		.i_pointer_sel(psel), .i_offset_sel(osel), .i_signed_ten_bit_literal(lit),
		.i_mac_valid(mac_v), .i_mac_x_mode(xm), .i_mac_y_mode(ym), .i_mac_x_sel(xs),
		.i_mac_y_sel(ys), .i_imm_kind(ik), .i_instr_word(iw), .i_imm_wide_sel(wide),
		.i_sixteen_bit_literal(l16), .i_fourteen_bit_literal(l14), .i_reg_array(regs),
		.o_effective_address(ea), .o_addr_valid(av), .o_mode_error(merr), .o_ptr_we(pwe),
		.o_ptr_sel(psl), .o_ptr_wdata(pwd), .o_x_effective_address(xea),
		.o_y_effective_address(yea), .o_mac_valid(mv), .o_x_ptr_we(xwe), .o_x_ptr_sel(xsl),
		.o_x_ptr_wdata(xwd), .o_y_ptr_we(ywe), .o_y_ptr_sel(ysl), .o_y_ptr_wdata(ywd),
		.o_immediate(imm));
	reg_file_model partner (.i_clk_sys(i_clk_sys), .i_load(ld), .i_load_sel(ld_sel),
		.i_load_val(ld_val), .i_we({ywe, xwe, pwe}), .i_sel({ysl, xsl, psl}),
		.i_wdata({ywd, xwd, pwd}), .o_reg_array(regs));
	// ==========
	// shared tasks
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task load(input logic [3:0] s, input logic [15:0] v);
		@(posedge i_clk_sys);
		ld <= 1'b1;
		ld_sel <= s;
		ld_val <= v;
		@(posedge i_clk_sys);
		ld <= 1'b0;
	endtask : load
	task fire;
		@(posedge i_clk_sys);
		op_v <= 1'b0;
		mac_v <= 1'b0;
		@(negedge i_clk_sys);
	endtask : fire
	task results;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	// ==========
	// scenarios
	task t_basic;
		logic [15:0] p, s, ea_e, wd_e;
		int m;
		for (int i = 0; i < 20; i++) begin
			m = i / 4;
			p = i[0] ? 16'hffff : 16'h2300;
			s = i[1] ? STEP_BYTE : STEP_WORD;
			ea_e = (m == 1) ? p + s : (m == 2) ? p - s : p;
			wd_e = (m == 1 || m == 3) ? p + s : p - s;
			load(4'h3, p);
			@(posedge i_clk_sys);
			mode <= ind_mode_t'(m);
			byte_op <= i[1];
			op_v <= 1'b1;
			fire();
			chk(ea, ea_e);
			chk({15'h0, av}, 16'h0001);
			chk({15'h0, pwe}, {15'h0, m != 0});
			if (m != 0) begin
				chk(pwd, wd_e);
				chk({12'h0, psl}, 16'h0003);
			end
			@(posedge i_clk_sys);
			#1;
			chk(regs[63:48], (m != 0) ? wd_e : p);
		end
		$display("test basic modes done");
	endtask : t_basic
	task off_case(input ind_mode_t m, input logic a, input logic b, input logic [9:0] l,
		input logic [15:0] ea_e, input logic err_e);
		@(posedge i_clk_sys);
		mode <= m;
		allow <= a;
		byte_op <= b;
		lit <= l;
		op_v <= 1'b1;
		fire();
		if (!err_e) chk(ea, ea_e);
		chk({14'h0, merr, av}, {14'h0, err_e, ~err_e});
		chk({15'h0, pwe}, 16'h0000);
	endtask : off_case
	task t_offset;
		load(4'h3, 16'hfff0);
		load(4'h4, 16'h0020);
		off_case(MODE_REG_OFFSET, 1'b1, 1'b0, 10'h000, 16'h0010, 1'b0);
		off_case(MODE_REG_OFFSET, 1'b1, 1'b1, 10'h000, 16'h0010, 1'b0);
		off_case(MODE_REG_OFFSET, 1'b0, 1'b0, 10'h000, 16'h0000, 1'b1);
		off_case(MODE_LIT_OFFSET, 1'b0, 1'b0, 10'h3e0, 16'hffd0, 1'b0);
		off_case(MODE_LIT_OFFSET, 1'b0, 1'b0, 10'h020, 16'h0010, 1'b0);
		$display("test offset modes done");
	endtask : t_offset
	task t_mac;
		logic [15:0] st, xp, yp;
		logic [7:0] sl_e;
		for (int i = 0; i < 8; i++) begin
			st = (i == 1 || i == 4) ? STEP_MAC_2 : (i == 2 || i == 5) ? STEP_MAC_4 : STEP_MAC_6;
			xp = i[0] ? 16'h0100 : 16'h1000;
			yp = i[1] ? 16'hfff0 : 16'h4000;
			sl_e = {i[0] ? REG_X_HI : REG_X_LO, i[1] ? REG_Y_HI : REG_Y_LO};
			load(4'h8, 16'h1000);
			load(4'h9, 16'h0100);
			load(4'ha, 16'h4000);
			load(4'hb, 16'hfff0);
			load(4'hc, 16'h0030);
			@(posedge i_clk_sys);
			xm <= mac_mode_t'(i);
			ym <= mac_mode_t'(i);
			xs <= i[0];
			ys <= i[1];
			mac_v <= 1'b1;
			fire();
			chk({15'h0, mv}, 16'h0001);
			chk(xea, (i == 7) ? 16'h0130 : xp);
			chk(yea, (i == 7) ? 16'h0020 : yp);
			chk({14'h0, xwe, ywe}, {14'h0, i != 0 && i != 7, i != 0 && i != 7});
			if (i != 0 && i != 7) begin
				chk({8'h0, xsl, ysl}, {8'h0, sl_e});
				chk(xwd, (i < 4) ? xp + st : xp - st);
				chk(ywd, (i < 4) ? yp + st : yp - st);
			end
		end
		$display("test prefetch modes done");
	endtask : t_mac
	task t_imm;
		logic [15:0] e [10] = '{16'h0000, 16'h000a, 16'hfffa, 16'h000a, 16'hffea,
			16'h00aa, 16'h02aa, 16'hfeaa, 16'h2abc, 16'hbeef};
		for (int i = 0; i < 10; i++) begin
			@(posedge i_clk_sys);
			ik <= imm_kind_t'((i < 8) ? i : i - 2);
			wide <= (i >= 8);
			@(posedge i_clk_sys);
			@(negedge i_clk_sys);
			chk(imm, e[i]);
		end
		$display("test immediates done");
	endtask : t_imm
	initial begin
		repeat (15) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk({13'h0, av, pwe, mv}, 16'h0000);
		chk(ea, 16'h0000);
		@(posedge i_clk_sys);
		i_resetn <= 1'b1;
		t_basic();
		t_offset();
		t_mac();
		t_imm();
		results();
	end
endmodule : indirect_address_generator_tb

// ==== tb/reg_file_model.sv ====
`timescale 1ns/1ps
module reg_file_model (
	input wire logic i_clk_sys,
	input wire logic i_load,
	input wire logic [3:0] i_load_sel,
	input wire logic [15:0] i_load_val,
	input wire logic [2:0] i_we,
	input wire logic [11:0] i_sel,
	input wire logic [47:0] i_wdata,
	output logic [255:0] o_reg_array
);
	// ==========
	// working registers, write-back lands on next edge
	always_ff @(posedge i_clk_sys) begin
		for (int k = 0; k < 3; k++) begin
			if (i_we[k]) begin
				o_reg_array[i_sel[4*k+:4]*16+:16] <= i_wdata[16*k+:16];
			end
		end
		if (i_load) begin
			o_reg_array[i_load_sel*16+:16] <= i_load_val;
		end
	end
endmodule : reg_file_model
